// [rtl/flash_clk_div.sv]
// flash_clk_div: derives the flash timing clock as a one-cycle enable pulse
// assumes: divider value is stable once written; bus clock on i_clk
`timescale 1ns/1ps
`default_nettype none
module flash_clk_div (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_en,
  input  wire logic [flash_seq_pkg::DIV_W-1:0] i_div,
  output logic                               o_tick
);
  logic [flash_seq_pkg::DIV_W+2:0] cnt_r;
  logic [flash_seq_pkg::DIV_W+2:0] cnt_nxt;
  logic                            tick_nxt;

  // divide by 8*(div+1): at 40 MHz a div of 24..32 yields 150..200 kHz
  always_comb begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (!i_en) begin
      cnt_nxt = '0;
    end else if (cnt_r == {i_div, 3'b111}) begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r  <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      o_tick <= tick_nxt;
    end
  end
endmodule : flash_clk_div
`default_nettype wire

// [rtl/flash_program_erase_sequencer.sv]
// flash_program_erase_sequencer: command intake, error checks and timing
// assumes: write strobes are one-cycle pulses from logic on I_CLK
//
// Functional notes
// - divider register takes only the first write after reset
// - divider writes ignored while the access error flag is set
// - timing clock rate comes from bus clock and divider value
// - program and erase pulses are timed in whole timing clock periods
// - byte program 9, page erase 4000, mass erase 20000 periods
// - burst byte takes 4 periods under burst conditions
// - sequence starts with an array write; address and data latched
// - page erase any address in page; mass erase/blank check any address
// - erase granule is a whole 512-byte page
// - second step writes command code; five codes valid
// - writing one to buffer empty flag launches the latched command
// - writing zero before launch aborts and sets access error
// - no new command starts while access error is set
// - command complete flag shows when the command has finished
// - pump stays on if next burst queued and same row
// - a row is 64 bytes; low six address bits zero start a row
// - first burst byte takes standard time, later ones burst time
// - new row in burst drops and restores high voltage, standard time
// - no queued burst at completion turns pump off
// - invalid command code sets access error
// - array write with buffer not empty sets access error
// - second command code write before launch sets access error
// - stop entry during program or erase aborts and sets access error
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_sequencer (
  input  wire logic                               I_CLK,
  input  wire logic                               I_RST,
  input  wire logic                               I_DIV_WR,
  input  wire logic [flash_seq_pkg::DIV_W-1:0]    I_DIV_DATA,
  input  wire logic                               I_ARRAY_WR,
  input  wire logic [flash_seq_pkg::ADDR_W-1:0]   I_ARRAY_ADDR,
  input  wire logic [7:0]                         I_ARRAY_DATA,
  input  wire logic                               I_CMD_WR,
  input  wire logic [7:0]                         I_CMD_DATA,
  input  wire logic                               I_STAT_WR,
  input  wire logic                               I_CBEF_WDATA,
  input  wire logic                               I_ACCERR_CLR,
  input  wire logic                               I_STOP,
  output logic [flash_seq_pkg::DIV_W-1:0]         O_DIV,
  output logic                                    O_DIV_DONE,
  output logic                                    O_ACCERR,
  output logic                                    O_CBEF,
  output logic                                    O_CCF,
  output logic                                    O_PUMP_EN,
  output logic                                    O_HV_EN,
  output logic [7:0]                              O_OP_CODE,
  output logic [flash_seq_pkg::ADDR_W-1:0]        O_OP_ADDR,
  output logic [7:0]                              O_OP_DATA
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic code_ok(input logic [7:0] c);
    code_ok = (c == flash_seq_pkg::CMD_BLANK) || (c == flash_seq_pkg::CMD_BYTE) ||
              (c == flash_seq_pkg::CMD_BURST) || (c == flash_seq_pkg::CMD_PAGE) ||
              (c == flash_seq_pkg::CMD_MASS);
  endfunction : code_ok

  // same row: upper address bits match and next is not a row start
  function automatic logic same_row(input logic [flash_seq_pkg::ADDR_W-1:0] a,
                                    input logic [flash_seq_pkg::ADDR_W-1:0] b);
    same_row = (a[flash_seq_pkg::ADDR_W-1:flash_seq_pkg::ROW_BITS] ==
                b[flash_seq_pkg::ADDR_W-1:flash_seq_pkg::ROW_BITS]) &&
               (b[flash_seq_pkg::ROW_BITS-1:0] != '0);
  endfunction : same_row

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [flash_seq_pkg::DIV_W-1:0] div_r, div_nxt;
  logic                            divset_r, divset_nxt;
  logic                            accerr_r, accerr_nxt;
  logic                            cbef_r, cbef_nxt;
  logic                            ccf_r, ccf_nxt;
  logic                            have_addr_r, have_addr_nxt;
  logic                            have_cmd_r, have_cmd_nxt;
  flash_seq_pkg::cmd_t             buf_r, buf_nxt;     // command buffer
  logic                            queued_r, queued_nxt;
  flash_seq_pkg::cmd_t             op_r, op_nxt;       // executing command
  flash_seq_pkg::state_t           st_r, st_nxt;
  logic                            pump_r, pump_nxt;
  logic                            hv_r, hv_nxt;
  logic                            tick;
  logic                            tmr_busy;
  logic                            tmr_done;
  logic                            tmr_load;
  logic [15:0]                     tmr_count;
  logic                            tmr_abort;
  logic                            take_buf;
  logic                            burst_fast;

  // ----------------------------------------------------------------
  // timing clock and pulse timer
  // ----------------------------------------------------------------
  flash_clk_div u_div (
    .i_clk  (I_CLK),
    .i_rst  (I_RST),
    .i_en   (divset_r),
    .i_div  (div_r),
    .o_tick (tick)
  );

  flash_pulse_timer u_tmr (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_load  (tmr_load),
    .i_count (tmr_count),
    .i_abort (tmr_abort),
    .i_tick  (tick),
    .o_busy  (tmr_busy),
    .o_done  (tmr_done)
  );

  // ----------------------------------------------------------------
  // divider register and command intake
  // ----------------------------------------------------------------
  // one write only, refused while access error stands
  always_comb begin
    div_nxt    = div_r;
    divset_nxt = divset_r;
    if (I_DIV_WR && !divset_r && !accerr_r) begin
      div_nxt    = I_DIV_DATA;
      divset_nxt = 1'b1;
    end
  end

  // intake sequence, error flag, buffer empty flag
  always_comb begin
    logic err_set;
    logic launch;
    err_set       = 1'b0;
    launch        = 1'b0;
    accerr_nxt    = accerr_r;
    cbef_nxt      = cbef_r;
    have_addr_nxt = have_addr_r;
    have_cmd_nxt  = have_cmd_r;
    buf_nxt       = buf_r;
    queued_nxt    = queued_r;
    if (I_ARRAY_WR) begin
      if (!cbef_r || have_addr_r || !divset_r || accerr_r) begin
        err_set = 1'b1;
      end else begin
        buf_nxt.addr  = I_ARRAY_ADDR;
        buf_nxt.data  = I_ARRAY_DATA;
        have_addr_nxt = 1'b1;
      end
    end
    if (I_CMD_WR) begin
      if (!have_addr_r || have_cmd_r || !code_ok(I_CMD_DATA)) begin
        err_set = 1'b1;
      end else begin
        buf_nxt.code = I_CMD_DATA;
        have_cmd_nxt = 1'b1;
      end
    end
    if (I_STAT_WR && cbef_r && have_addr_r) begin
      if (!I_CBEF_WDATA) begin
        err_set = 1'b1;
      end else if (have_cmd_r && !accerr_r) begin
        launch = 1'b1;
      end
    end
    if (I_STOP && (st_r != flash_seq_pkg::ST_IDLE)) begin
      err_set = 1'b1;
    end
    if (err_set) begin
      have_addr_nxt = 1'b0;
      have_cmd_nxt  = 1'b0;
    end
    if (launch) begin
      cbef_nxt      = 1'b0;
      queued_nxt    = 1'b1;
      have_addr_nxt = 1'b0;
      have_cmd_nxt  = 1'b0;
    end else if (take_buf) begin
      cbef_nxt   = 1'b1;
      queued_nxt = 1'b0;
    end
    if (I_STOP && (st_r != flash_seq_pkg::ST_IDLE)) begin
      queued_nxt = 1'b0;
      cbef_nxt   = 1'b1;
    end
    // set wins over clear
    if (I_ACCERR_CLR) begin
      accerr_nxt = 1'b0;
    end
    if (err_set) begin
      accerr_nxt = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // execution
  // ----------------------------------------------------------------
  // next command chains as burst on the same row with pump kept on
  assign burst_fast = (op_r.code == flash_seq_pkg::CMD_BURST) &&
                      (buf_r.code == flash_seq_pkg::CMD_BURST) &&
                      same_row(op_r.addr, buf_r.addr);

  always_comb begin
    take_buf  = 1'b0;
    tmr_load  = 1'b0;
    tmr_count = flash_seq_pkg::CYC_BYTE;
    tmr_abort = 1'b0;
    st_nxt    = st_r;
    op_nxt    = op_r;
    pump_nxt  = pump_r;
    hv_nxt    = hv_r;
    ccf_nxt   = ccf_r;
    if (queued_r || (cbef_r == 1'b0)) begin
      ccf_nxt = 1'b0;
    end
    case (st_r)
      flash_seq_pkg::ST_IDLE: begin
        if (queued_r && !I_STOP) begin
          take_buf = 1'b1;
          op_nxt   = buf_r;
          tmr_load = 1'b1;
          pump_nxt = 1'b1;
          hv_nxt   = 1'b1;
          st_nxt   = flash_seq_pkg::ST_RUN;
          case (buf_r.code)
            flash_seq_pkg::CMD_PAGE:  tmr_count = flash_seq_pkg::CYC_PAGE;
            flash_seq_pkg::CMD_MASS:  tmr_count = flash_seq_pkg::CYC_MASS;
            flash_seq_pkg::CMD_BLANK: tmr_count = flash_seq_pkg::CYC_BLANK;
            default:                  tmr_count = flash_seq_pkg::CYC_BYTE;
          endcase
        end
      end
      flash_seq_pkg::ST_RUN: begin
        if (I_STOP) begin
          tmr_abort = 1'b1;
          pump_nxt  = 1'b0;
          hv_nxt    = 1'b0;
          st_nxt    = flash_seq_pkg::ST_IDLE;
        end else if (tmr_done) begin
          if (queued_r && burst_fast) begin
            take_buf  = 1'b1;
            op_nxt    = buf_r;
            tmr_load  = 1'b1;
            tmr_count = flash_seq_pkg::CYC_BURST;
          end else if (queued_r && (op_r.code == flash_seq_pkg::CMD_BURST) &&
                       (buf_r.code == flash_seq_pkg::CMD_BURST)) begin
            pump_nxt = 1'b0;
            hv_nxt   = 1'b0;
            st_nxt   = flash_seq_pkg::ST_GAP;
          end else begin
            pump_nxt = 1'b0;
            hv_nxt   = 1'b0;
            st_nxt   = flash_seq_pkg::ST_GAP;
          end
        end
      end
      flash_seq_pkg::ST_GAP: begin
        // one idle cycle with high voltage off
        st_nxt = flash_seq_pkg::ST_IDLE;
        if (!queued_r) begin
          ccf_nxt = 1'b1;
        end
      end
      default: begin
        st_nxt = flash_seq_pkg::ST_IDLE;
      end
    endcase
    if (st_r != flash_seq_pkg::ST_IDLE && I_STOP) begin
      ccf_nxt = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      div_r       <= flash_seq_pkg::DIV_RST;
      divset_r    <= 1'b0;
      accerr_r    <= 1'b0;
      cbef_r      <= 1'b1;
      ccf_r       <= 1'b1;
      have_addr_r <= 1'b0;
      have_cmd_r  <= 1'b0;
      buf_r       <= '0;
      queued_r    <= 1'b0;
      op_r        <= '0;
      st_r        <= flash_seq_pkg::ST_IDLE;
      pump_r      <= 1'b0;
      hv_r        <= 1'b0;
    end else begin
      div_r       <= div_nxt;
      divset_r    <= divset_nxt;
      accerr_r    <= accerr_nxt;
      cbef_r      <= cbef_nxt;
      ccf_r       <= ccf_nxt;
      have_addr_r <= have_addr_nxt;
      have_cmd_r  <= have_cmd_nxt;
      buf_r       <= buf_nxt;
      queued_r    <= queued_nxt;
      op_r        <= op_nxt;
      st_r        <= st_nxt;
      pump_r      <= pump_nxt;
      hv_r        <= hv_nxt;
    end
  end

  // outputs straight from flops
  assign O_DIV      = div_r;
  assign O_DIV_DONE = divset_r;
  assign O_ACCERR   = accerr_r;
  assign O_CBEF     = cbef_r;
  assign O_CCF      = ccf_r;
  assign O_PUMP_EN  = pump_r;
  assign O_HV_EN    = hv_r;
  assign O_OP_CODE  = op_r.code;
  assign O_OP_ADDR  = op_r.addr;
  assign O_OP_DATA  = op_r.data;
endmodule : flash_program_erase_sequencer
`default_nettype wire

// [rtl/flash_pulse_timer.sv]
// flash_pulse_timer: counts flash timing clock ticks for one operation
// assumes: i_tick is a one-cycle enable from flash_clk_div
`timescale 1ns/1ps
`default_nettype none
module flash_pulse_timer (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_load,
  input  wire logic [15:0] i_count,
  input  wire logic        i_abort,
  input  wire logic        i_tick,
  output logic             o_busy,
  output logic             o_done
);
  logic [15:0] rem_r;
  logic [15:0] rem_nxt;
  logic        busy_nxt;
  logic        done_nxt;

  // load, count down on ticks, pulse done at zero
  always_comb begin
    rem_nxt  = rem_r;
    busy_nxt = o_busy;
    done_nxt = 1'b0;
    if (i_abort) begin
      busy_nxt = 1'b0;
    end else if (i_load) begin
      rem_nxt  = i_count;
      busy_nxt = 1'b1;
    end else if (o_busy && i_tick) begin
      if (rem_r == 16'h0001) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
      rem_nxt = rem_r - 16'h0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rem_r  <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      rem_r  <= rem_nxt;
      o_busy <= busy_nxt;
      o_done <= done_nxt;
    end
  end
endmodule : flash_pulse_timer
`default_nettype wire

// [rtl/flash_seq_pkg.sv]
// flash_seq_pkg: shared constants and types for the flash program/erase sequencer
// assumes: single 40 MHz bus clock, no register bus (plain control ports)
package flash_seq_pkg;

  // command codes
  localparam logic [7:0] CMD_BLANK  = 8'h05;
  localparam logic [7:0] CMD_BYTE   = 8'h20;
  localparam logic [7:0] CMD_BURST  = 8'h25;
  localparam logic [7:0] CMD_PAGE   = 8'h40;
  localparam logic [7:0] CMD_MASS   = 8'h41;

  // geometry
  localparam int ADDR_W    = 16;
  localparam int DIV_W     = 7;
  localparam int ROW_BITS  = 6;   // 64-byte row
  localparam int PAGE_BITS = 9;   // 512-byte page

  // operation lengths in flash timing clock periods
  localparam logic [15:0] CYC_BYTE  = 16'h0009;
  localparam logic [15:0] CYC_BURST = 16'h0004;
  localparam logic [15:0] CYC_PAGE  = 16'h0FA0;  // 4000
  localparam logic [15:0] CYC_MASS  = 16'h4E20;  // 20000
  localparam logic [15:0] CYC_BLANK = 16'h0009;  // blank check length (chosen)

  // reset values
  localparam logic [DIV_W-1:0] DIV_RST = 7'h00;

  // one latched command
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
    logic [7:0]        code;
  } cmd_t;

  // sequencer states, gray along idle->run->gap path
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_GAP  = 2'b11
  } state_t;

endpackage : flash_seq_pkg

// [tb/flash_array_model.sv]
// flash_array_model: flash cell map and high-voltage monitor for the sequencer
// assumes: op outputs of the sequencer are valid while high voltage is on
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_hv_en,
  input  wire logic [7:0]  i_op_code,
  input  wire logic [15:0] i_op_addr,
  output var  logic [31:0] o_pulses,
  output var  logic [31:0] o_last_len,
  output var  logic        o_reprog
);
  bit          prog [int];
  logic        hv_q;
  logic [15:0] addr_q;
  logic [31:0] len;
  // cell map survives reset, pulse statistics do not
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hv_q = 1'b0;
      addr_q = 16'h0000;
      len = 32'h0000_0000;
      o_pulses = 32'h0000_0000;
      o_last_len = 32'h0000_0000;
      o_reprog = 1'b0;
    end else begin
      if (i_hv_en && (!hv_q || i_op_addr != addr_q)) begin
        case (i_op_code)
          flash_seq_pkg::CMD_BYTE, flash_seq_pkg::CMD_BURST: begin
            if (prog.exists(i_op_addr)) o_reprog = 1'b1;
            prog[i_op_addr] = 1'b1;
          end
          flash_seq_pkg::CMD_PAGE: begin
            for (int a = 0; a < 512; a++) prog.delete({i_op_addr[15:9], a[8:0]});
          end
          flash_seq_pkg::CMD_MASS: prog.delete();
          default: ;
        endcase
      end
      if (i_hv_en && !hv_q) o_pulses = o_pulses + 32'h0000_0001;
      if (i_hv_en) len = len + 32'h0000_0001;
      else begin
        if (hv_q) o_last_len = len;
        len = 32'h0000_0000;
      end
      hv_q = i_hv_en;
      addr_q = i_op_addr;
    end
  end
endmodule : flash_array_model
`default_nettype wire

// [tb/flash_program_erase_sequencer_asserts.sv]
// flash_seq_asserts: protocol checks on the sequencer's top ports
// assumes: one clock domain, bound to every sequencer instance
`timescale 1ns/1ps
`default_nettype none
module flash_seq_asserts (
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic        I_DIV_WR,
  input wire logic [6:0]  I_DIV_DATA,
  input wire logic        I_ARRAY_WR,
  input wire logic [15:0] I_ARRAY_ADDR,
  input wire logic [7:0]  I_ARRAY_DATA,
  input wire logic        I_CMD_WR,
  input wire logic [7:0]  I_CMD_DATA,
  input wire logic        I_STAT_WR,
  input wire logic        I_CBEF_WDATA,
  input wire logic        I_ACCERR_CLR,
  input wire logic        I_STOP,
  input wire logic [6:0]  O_DIV,
  input wire logic        O_DIV_DONE,
  input wire logic        O_ACCERR,
  input wire logic        O_CBEF,
  input wire logic        O_CCF,
  input wire logic        O_PUMP_EN,
  input wire logic        O_HV_EN,
  input wire logic [7:0]  O_OP_CODE,
  input wire logic [15:0] O_OP_ADDR,
  input wire logic [7:0]  O_OP_DATA
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [31:0] hv_len_r;
  logic [31:0] hv_len_nxt;
  logic [31:0] unit;
  logic [31:0] ticks;
  logic        code_ok;
  // cycles spent with high voltage on
  always_comb begin
    hv_len_nxt = O_HV_EN ? hv_len_r + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) hv_len_r <= 32'h0000_0000;
    else hv_len_r <= hv_len_nxt;
  end
  // timing clock period in bus cycles and expected tick count
  assign unit = {21'h00_0000, {1'b0, O_DIV} + 8'h01, 3'h0};
  assign ticks = (O_OP_CODE == flash_seq_pkg::CMD_PAGE) ? {16'h0000, flash_seq_pkg::CYC_PAGE} :
                 (O_OP_CODE == flash_seq_pkg::CMD_MASS) ? {16'h0000, flash_seq_pkg::CYC_MASS} :
                 {16'h0000, flash_seq_pkg::CYC_BYTE};
  assign code_ok = I_CMD_DATA inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  sequence s_armed;
    I_ARRAY_WR && O_CBEF && !O_ACCERR && O_DIV_DONE && O_CCF && !O_HV_EN && !I_STOP;
  endsequence
  sequence s_launch;
    s_armed ##1 (I_CMD_WR && code_ok) ##1 (I_STAT_WR && I_CBEF_WDATA);
  endsequence
  sequence s_done;
    $fell(O_HV_EN) && !$past(I_STOP) && !I_STOP && O_OP_CODE != flash_seq_pkg::CMD_BURST;
  endsequence
  a_div_once: assert property (O_DIV_DONE && I_DIV_WR |=> $stable(O_DIV))
    else $error("divider changed after first write");
  a_div_blocked: assert property (O_ACCERR && !I_ACCERR_CLR && !O_DIV_DONE && I_DIV_WR
    |=> !O_DIV_DONE) else $error("divider taken with access error set");
  a_launch_walk: assert property (s_launch |=> !O_CBEF ##1
    (O_HV_EN && O_PUMP_EN && O_CBEF && !O_CCF)) else $error("launch walk broken");
  a_abort_err: assert property (s_armed ##1 (I_STAT_WR && !I_CBEF_WDATA) |=> O_ACCERR)
    else $error("abort did not flag error");
  a_bad_code: assert property (I_CMD_WR && !code_ok |=> O_ACCERR)
    else $error("invalid code not flagged");
  a_busy_write: assert property (I_ARRAY_WR && !O_CBEF |=> O_ACCERR)
    else $error("array write with full buffer not flagged");
  a_cmd_twice: assert property (I_CMD_WR ##1 I_CMD_WR |=> O_ACCERR)
    else $error("second code write not flagged");
  a_err_blocks: assert property (O_ACCERR && !I_ACCERR_CLR && O_CBEF && I_STAT_WR |=> O_CBEF)
    else $error("launch accepted with access error");
  a_stop_abort: assert property (O_HV_EN && I_STOP |-> ##[1:2]
    (!O_HV_EN && !O_PUMP_EN && O_ACCERR)) else $error("stop did not abort");
  a_op_time: assert property (s_done |-> hv_len_r >= (ticks - 1) * unit &&
    hv_len_r <= (ticks + 1) * unit + 4) else $error("operation length off");
  a_done_flag: assert property (s_done ##0 O_CBEF |=> O_CCF)
    else $error("complete flag late");
endmodule : flash_seq_asserts
bind flash_program_erase_sequencer flash_seq_asserts u_chk (.*);
`default_nettype wire

// [tb/tb_flash_program_erase_sequencer.sv]
// tb_flash_program_erase_sequencer: directed bench for the flash sequencer
// assumes: checker bound to the design, divider 0 for a fast timing clock, then 0x18 after the second reset
`timescale 1ns/1ps
`default_nettype none
module tb_flash_program_erase_sequencer;
  logic        I_CLK, I_RST, I_DIV_WR, I_ARRAY_WR, I_CMD_WR, I_STAT_WR;
  logic        I_CBEF_WDATA, I_ACCERR_CLR, I_STOP;
  logic        O_DIV_DONE, O_ACCERR, O_CBEF, O_CCF, O_PUMP_EN, O_HV_EN, reprog;
  logic [6:0]  I_DIV_DATA, O_DIV;
  logic [7:0]  I_ARRAY_DATA, I_CMD_DATA, O_OP_CODE, O_OP_DATA;
  logic [15:0] I_ARRAY_ADDR, O_OP_ADDR;
  logic [31:0] pulses, last_len, p;
  int          n_mismatch, checks, cyc, unit;
  flash_program_erase_sequencer uut (.*);
  flash_array_model u_array (.i_clk(I_CLK), .i_rst(I_RST), .i_hv_en(O_HV_EN),
    .i_op_code(O_OP_CODE), .i_op_addr(O_OP_ADDR), .o_pulses(pulses),
    .o_last_len(last_len), .o_reprog(reprog));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic step(input logic aw, input logic cw, input logic sw, input logic sv);
    I_ARRAY_WR = aw;
    I_CMD_WR = cw;
    I_STAT_WR = sw;
    I_CBEF_WDATA = sv;
    @(posedge I_CLK);
    #1;
  endtask : step
  task automatic pulse_div(input logic [6:0] v);
    I_DIV_DATA = v;
    I_DIV_WR = 1'b1;
    @(posedge I_CLK);
    #1;
    I_DIV_WR = 1'b0;
    @(posedge I_CLK);
    #1;
  endtask : pulse_div
  task automatic clr_err();
    I_ACCERR_CLR = 1'b1;
    @(posedge I_CLK);
    #1;
    I_ACCERR_CLR = 1'b0;
  endtask : clr_err
  // full three-step sequence, returns a fixed two cycles after the launch write
  task automatic launch(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c);
    I_ARRAY_ADDR = a;
    I_ARRAY_DATA = d;
    I_CMD_DATA = c;
    step(1'b1, 1'b0, 1'b0, 1'b0);
    step(1'b0, 1'b1, 1'b0, 1'b0);
    step(1'b0, 1'b0, 1'b1, 1'b1);
    step(1'b0, 1'b0, 1'b0, 1'b0);
    @(posedge I_CLK);
    #1;
  endtask : launch
  task automatic wait_done();
    int k;
    k = 0;
    while (O_CCF !== 1'b1 && k < 40000) begin
      @(posedge I_CLK);
      #1;
      k++;
    end
    check("complete", O_CCF, 1'b1);
  endtask : wait_done
  function automatic logic [31:0] near(input logic [31:0] n, input logic [31:0] t);
    return {31'h0, n >= (t - 1) * unit && n <= (t + 1) * unit + 4};
  endfunction : near
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_setup();
    check("ccf", O_CCF, 1'b1);
    check("cbef", O_CBEF, 1'b1);
    I_ARRAY_ADDR = 16'h0010;
    step(1'b1, 1'b0, 1'b0, 1'b0);
    step(1'b0, 1'b0, 1'b0, 1'b0);
    check("early write", O_ACCERR, 1'b1);
    pulse_div(7'h05);
    check("div blocked", O_DIV_DONE, 1'b0);
    clr_err();
    pulse_div(7'h00);
    check("div done", O_DIV_DONE, 1'b1);
    pulse_div(7'h05);
    check("div once", O_DIV, 7'h00);
    $display("test setup finished");
  endtask : t_setup
  task automatic t_single(input logic [7:0] c, input logic [31:0] t);
    launch(16'h0123, 8'h5A, c);
    check("op addr", O_OP_ADDR, 16'h0123);
    check("op data", O_OP_DATA, 8'h5A);
    check("op code", O_OP_CODE, c);
    check("ccf run", O_CCF, 1'b0);
    wait_done();
    check("length", near(last_len, t), 1);
    check("pump off", O_PUMP_EN, 1'b0);
    $display("test single %h finished", c);
  endtask : t_single
  task automatic t_burst(input logic [15:0] a, input logic [31:0] n, input logic [31:0] t);
    p = pulses;
    launch(a, 8'h11, flash_seq_pkg::CMD_BURST);
    launch(a + 16'h0001, 8'h22, flash_seq_pkg::CMD_BURST);
    wait_done();
    check("burst pulses", pulses - p, n);
    check("burst length", near(last_len, t), 1);
    check("burst pump", O_PUMP_EN, 1'b0);
    check("no reprogram", reprog, 1'b0);
    $display("test burst %h finished", a);
  endtask : t_burst
  task automatic t_errors();
    I_CMD_DATA = 8'h33;
    step(1'b1, 1'b0, 1'b0, 1'b0);
    step(1'b0, 1'b1, 1'b0, 1'b0);
    step(1'b0, 1'b0, 1'b0, 1'b0);
    check("bad code", O_ACCERR, 1'b1);
    launch(16'h0300, 8'h01, flash_seq_pkg::CMD_BYTE);
    check("blocked hv", O_HV_EN, 1'b0);
    clr_err();
    step(1'b1, 1'b0, 1'b0, 1'b0);
    step(1'b0, 1'b0, 1'b1, 1'b0);
    step(1'b0, 1'b0, 1'b0, 1'b0);
    check("abort", O_ACCERR, 1'b1);
    clr_err();
    step(1'b1, 1'b0, 1'b0, 1'b0);
    step(1'b0, 1'b1, 1'b0, 1'b0);
    step(1'b0, 1'b1, 1'b0, 1'b0);
    step(1'b0, 1'b0, 1'b0, 1'b0);
    check("code twice", O_ACCERR, 1'b1);
    clr_err();
    I_ARRAY_ADDR = 16'h0020;
    step(1'b1, 1'b0, 1'b0, 1'b0);
    step(1'b0, 1'b1, 1'b0, 1'b0);
    step(1'b0, 1'b0, 1'b1, 1'b1);
    step(1'b1, 1'b0, 1'b0, 1'b0);
    step(1'b0, 1'b0, 1'b0, 1'b0);
    check("busy write", O_ACCERR, 1'b1);
    wait_done();
    clr_err();
    launch(16'h0000, 8'h00, flash_seq_pkg::CMD_MASS);
    repeat (50) @(posedge I_CLK);
    #1;
    I_STOP = 1'b1;
    repeat (3) @(posedge I_CLK);
    #1;
    check("stop hv", O_HV_EN, 1'b0);
    check("stop err", O_ACCERR, 1'b1);
    I_STOP = 1'b0;
    clr_err();
    $display("test errors finished");
  endtask : t_errors
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    I_CLK = 1'b0;
    forever #12.5 I_CLK = ~I_CLK;
  end
  always @(posedge I_CLK) begin
    cyc++;
    if (cyc == 50000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    {I_DIV_WR, I_ARRAY_WR, I_CMD_WR, I_STAT_WR, I_CBEF_WDATA, I_ACCERR_CLR, I_STOP} = 7'h00;
    {I_DIV_DATA, I_ARRAY_ADDR, I_ARRAY_DATA, I_CMD_DATA} = 39'h00_0000_0000;
    unit = 8;
    I_RST = 1'b1;
    repeat (4) @(posedge I_CLK);
    #1;
    I_RST = 1'b0;
    t_setup();
    t_single(flash_seq_pkg::CMD_BYTE, 9);
    t_single(flash_seq_pkg::CMD_PAGE, 4000);
    t_single(flash_seq_pkg::CMD_BYTE, 9);
    t_single(flash_seq_pkg::CMD_BLANK, 9);
    t_burst(16'h0100, 1, 13);
    t_burst(16'h013F, 2, 9);
    t_errors();
    // second reset: divider set for a 200 kHz timing clock
    I_RST = 1'b1;
    @(posedge I_CLK);
    #1;
    I_RST = 1'b0;
    unit = 200;
    pulse_div(7'h18);
    t_burst(16'h0200, 1, 13);
    test_done();
  end
endmodule : tb_flash_program_erase_sequencer
`default_nettype wire
